// ==== src/sfp_pkg.sv ====
// Shared constants, types and helpers for the speech frame command logic.
package sfp_pkg;
  localparam logic [15:0] CMD_THR_SET = 16'hCF99;
  localparam logic [15:0] CMD_LVL_RD = 16'hCF88;
  localparam logic [15:0] THR_RESET = 16'h0100;
  localparam logic [15:0] ERASE_WORD = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] PB_TOP = 4'h2;
  localparam logic [1:0] PB_FIX = 2'h3;
  localparam int PB_FMT_LSB = 4;
  localparam int PB_PATH_LSB = 0;
  localparam logic [2:0] FMT_COMP = 3'h0;
  localparam logic [2:0] FMT_PCM = 3'h2;
  localparam logic [2:0] FMT_S8 = 3'h4;
  localparam logic [2:0] FMT_U8 = 3'h5;
  localparam logic [2:0] FMT_L16 = 3'h6;
  localparam logic [1:0] PATH_REG = 2'h0;
  localparam logic [1:0] PATH_ALIGN = 2'h1;
  localparam logic [1:0] PATH_RSV = 2'h2;
  localparam logic [1:0] PATH_BUF = 2'h3;
  localparam logic [3:0] RATE_85 = 4'h0;
  localparam logic [3:0] RATE_63 = 4'h1;
  localparam logic [3:0] RATE_53 = 4'h2;
  localparam logic [3:0] RATE_48 = 4'h3;
  localparam logic [3:0] RATE_41 = 4'h4;
  localparam logic [1:0] FT_63 = 2'h0;
  localparam logic [1:0] FT_53 = 2'h1;
  localparam logic [1:0] FT_CNF = 2'h2;
  localparam logic [1:0] FT_REP = 2'h3;
  localparam logic [7:0] SIG_63 = 8'h0C;
  localparam logic [7:0] SIG_53 = 8'h0A;
  localparam logic [7:0] SIG_CNF = 8'h02;
  localparam logic [7:0] SIG_REP = 8'h01;
  localparam logic [7:0] WORDS_85 = 8'h10;
  localparam logic [7:0] WORDS_48 = 8'h09;
  localparam logic [7:0] WORDS_41 = 8'h08;
  localparam logic [7:0] WORDS_PCM = 8'h78;
  localparam logic [7:0] WORDS_L16 = 8'hF0;
  localparam logic [7:0] SAMPLES_PER_FRAME = 8'hF0;
  localparam int LEVEL_SHIFT = 8;
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_FRAME = 5'h08;
  localparam logic [4:0] REG_RATE = 5'h0C;
  localparam logic [4:0] REG_HSTAT = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KIND_PLAIN, KIND_FULL63, KIND_FULL53, KIND_CNF, KIND_REPEAT, KIND_SILENCE, KIND_ERASE
  } sfp_kind_type;

  function automatic logic [7:0] frame_words(input logic [2:0] fmt, input logic [3:0] rate);
    frame_words = WORDS_PCM;
    if (fmt == FMT_COMP) begin
      case (rate)
        RATE_63: frame_words = SIG_63;
        RATE_53: frame_words = SIG_53;
        RATE_48: frame_words = WORDS_48;
        RATE_41: frame_words = WORDS_41;
        default: frame_words = WORDS_85;
      endcase
    end else if (fmt == FMT_L16) begin
      frame_words = WORDS_L16;
    end
  endfunction

  function automatic logic play_word_ok(input logic [15:0] w);
    logic [2:0] f;
    f = w[PB_FMT_LSB +: 3];
    play_word_ok = (w[15:12] == PB_TOP) && (w[11:10] == PB_FIX) && (w[9:7] == 3'h0)
      && (w[3:2] == 2'h0) && (w[PB_PATH_LSB +: 2] != PATH_RSV)
      && (f inside {FMT_COMP, FMT_PCM, FMT_S8, FMT_U8, FMT_L16});
  endfunction

  function automatic logic has_type_bits(input logic [3:0] rate);
    has_type_bits = (rate == RATE_63) || (rate == RATE_53);
  endfunction
endpackage

// ==== src/sfp_if.sv ====
// Parallel host port joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
interface sfp_if;
  logic cmd_wr;
  logic [15:0] cmd_word;
  logic [15:0] sts_word;
  logic sts_pending;
  logic sts_rd;
  logic frm_wr;
  logic [15:0] frm_word;
  logic [3:0] speech_rate;

  modport dev (
    input cmd_wr, cmd_word, sts_rd, frm_wr, frm_word, speech_rate,
    output sts_word, sts_pending
  );
  modport host (
    output cmd_wr, cmd_word, sts_rd, frm_wr, frm_word, speech_rate,
    input sts_word, sts_pending
  );
endinterface
`default_nettype wire

// ==== src/sfp_device.sv ====
// Device end: command interpreter, record level meter and playback frame checker.
`timescale 1ns/1ps
`default_nettype none
module sfp_device (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Host port
  sfp_if.dev port,
  // Record samples, taken before volume scaling and gain control
  input wire logic sample_valid_in,
  input wire logic [15:0] sample_in,
  // Record level
  output logic [15:0] level_out,
  output logic peak_out,
  // Playback session
  output logic session_active_out,
  output logic [2:0] playback_format_select_out,
  output logic [1:0] transfer_path_select_out,
  output logic [7:0] session_words_out,
  // Playback frame events
  output logic frame_done_out,
  output sfp_pkg::sfp_kind_type frame_kind_out,
  output logic pad_error_out
);
  import sfp_pkg::*;

  typedef enum logic {ST_CMD, ST_THR} sfp_cmd_st_type;

  sfp_cmd_st_type st_q, st_d;
  logic [15:0] thr_q;
  logic [15:0] sts_q;
  logic pend_q;
  logic [15:0] level_q;
  logic peak_q;
  logic [23:0] acc_q;
  logic [7:0] cnt_q;
  logic active_q;
  logic [2:0] fmt_q;
  logic [1:0] path_q;
  logic [7:0] size_q;
  logic [7:0] idx_q;
  logic [7:0] lnz_q;
  logic [15:0] w0_q;
  logic [15:0] w1_q;
  logic done_q;
  sfp_kind_type kind_q;
  logic perr_q;

  // Command decode.
  wire [15:0] cw = port.cmd_word;
  wire is_thr_set = cw == CMD_THR_SET;
  wire is_lvl_rd = cw[15:1] == CMD_LVL_RD[15:1];
  wire is_play = play_word_ok(cw);
  wire [2:0] cmd_fmt = cw[PB_FMT_LSB +: 3];
  wire [1:0] cmd_path = cw[PB_PATH_LSB +: 2];
  wire thr_load = port.cmd_wr && (st_q == ST_THR);
  wire play_load = port.cmd_wr && (st_q == ST_CMD) && is_play;

  logic [15:0] resp_d;
  always_comb begin
    resp_d = WORD_ZERO;
    st_d = st_q;
    if (st_q == ST_THR) begin
      resp_d = cw;
      st_d = ST_CMD;
    end else if (is_thr_set) begin
      resp_d = cw;
      st_d = ST_THR;
    end else if (is_lvl_rd) begin
      resp_d = cw[0] ? thr_q : level_q;
    end else if (is_play) begin
      resp_d = cw;
    end
  end

  // A read that lands with a new response keeps the flag set.
  wire pend_d = port.cmd_wr || (pend_q && !port.sts_rd);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= ST_CMD;
      thr_q <= THR_RESET;
      sts_q <= WORD_ZERO;
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      if (port.cmd_wr) begin
        st_q <= st_d;
        sts_q <= resp_d;
      end
      if (thr_load) begin
        thr_q <= cw;
      end
    end
  end

  // Level meter: magnitudes of one frame summed, then scaled down by 256.
  wire [16:0] s_ext = {sample_in[15], sample_in};
  wire [16:0] mag = sample_in[15] ? (~s_ext + 17'h1) : s_ext;
  wire [23:0] sum_d = acc_q + {7'h0, mag};
  wire frame_end = cnt_q == (SAMPLES_PER_FRAME - 8'h1);
  wire [15:0] new_level = sum_d[LEVEL_SHIFT +: 16];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= 24'h0;
      cnt_q <= 8'h0;
      level_q <= WORD_ZERO;
      peak_q <= 1'b0;
    end else if (sample_valid_in) begin
      if (frame_end) begin
        acc_q <= 24'h0;
        cnt_q <= 8'h0;
        level_q <= new_level;
        peak_q <= new_level > thr_q;
      end else begin
        acc_q <= sum_d;
        cnt_q <= cnt_q + 8'h1;
      end
    end
  end

  // Playback session: the frame length is frozen when playback starts.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_q <= 1'b0;
      fmt_q <= FMT_COMP;
      path_q <= PATH_REG;
      size_q <= WORDS_85;
    end else if (play_load) begin
      active_q <= 1'b1;
      fmt_q <= cmd_fmt;
      path_q <= cmd_path;
      size_q <= frame_words(cmd_fmt, port.speech_rate);
    end
  end

  // Frame checker, one word per write.
  wire fw = port.frm_wr && active_q;
  wire [15:0] fd = port.frm_word;
  wire first = idx_q == 8'h0;
  wire last = idx_q == (size_q - 8'h1);
  wire nz = fd != WORD_ZERO;
  wire [7:0] lnz_now = nz ? (idx_q + 8'h1) : (first ? 8'h0 : lnz_q);
  wire [15:0] w0_now = first ? fd : w0_q;
  wire [15:0] w1_now = (idx_q == 8'h1) ? fd : w1_q;
  wire [3:0] rate = port.speech_rate;
  wire erase_ok = rate inside {RATE_63, RATE_53, RATE_48, RATE_41};
  wire erase_pat = (w0_now == ERASE_WORD) && (w1_now == ERASE_WORD) && (lnz_now <= 8'h2);
  wire [1:0] ftype = w0_now[1:0];

  sfp_kind_type kind_d;
  logic [7:0] sig_d;
  logic perr_d;
  always_comb begin
    kind_d = KIND_PLAIN;
    sig_d = size_q;
    if (fmt_q != FMT_COMP) begin
      kind_d = KIND_PLAIN;
    end else if (lnz_now == 8'h0) begin
      kind_d = KIND_SILENCE;
    end else if (erase_pat && erase_ok) begin
      kind_d = KIND_ERASE;
    end else if (has_type_bits(rate)) begin
      unique case (ftype)
        FT_63: begin
          kind_d = KIND_FULL63;
          sig_d = SIG_63;
        end
        FT_53: begin
          kind_d = KIND_FULL53;
          sig_d = SIG_53;
        end
        FT_CNF: begin
          kind_d = KIND_CNF;
          sig_d = SIG_CNF;
        end
        FT_REP: begin
          kind_d = KIND_REPEAT;
          sig_d = SIG_REP;
        end
      endcase
    end else begin
      kind_d = KIND_PLAIN;
    end
    perr_d = lnz_now > sig_d;
    if (kind_d == KIND_REPEAT && w0_now[15:2] != 14'h0) begin
      perr_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx_q <= 8'h0;
      lnz_q <= 8'h0;
      w0_q <= WORD_ZERO;
      w1_q <= WORD_ZERO;
      done_q <= 1'b0;
      kind_q <= KIND_PLAIN;
      perr_q <= 1'b0;
    end else begin
      done_q <= fw && last;
      if (play_load) begin
        idx_q <= 8'h0;
      end else if (fw) begin
        idx_q <= last ? 8'h0 : (idx_q + 8'h1);
        lnz_q <= lnz_now;
        w0_q <= w0_now;
        w1_q <= w1_now;
        if (last) begin
          kind_q <= kind_d;
          perr_q <= perr_d;
        end
      end
    end
  end

  assign port.sts_word = sts_q;
  assign port.sts_pending = pend_q;
  assign level_out = level_q;
  assign peak_out = peak_q;
  assign session_active_out = active_q;
  assign playback_format_select_out = fmt_q;
  assign transfer_path_select_out = path_q;
  assign session_words_out = size_q;
  assign frame_done_out = done_q;
  assign frame_kind_out = kind_q;
  assign pad_error_out = perr_q;
endmodule
`default_nettype wire

// ==== src/sfp_host.sv ====
// Host end: AXI4-Lite register slave that drives commands and frames into the host port.
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // AXI4-Lite write channels
  input wire logic [4:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [4:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Host port
  sfp_if.host port
);
  import sfp_pkg::*;

  logic [4:0] aw_q;
  logic aw_full_q;
  logic [15:0] wd_q;
  logic [1:0] ws_q;
  logic w_full_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic out_q;
  logic [3:0] rate_q;
  logic [15:0] last_cmd_q;
  logic [7:0] size_q;
  logic [7:0] idx_q;
  logic [1:0] mask_q;
  logic cmd_wr_q;
  logic [15:0] cmd_word_q;
  logic frm_wr_q;
  logic [15:0] frm_word_q;

  wire do_wr = aw_full_q && w_full_q && !bvalid_q;
  wire full16 = ws_q == 2'h3;
  wire wr_cmd = do_wr && (aw_q == REG_CMD) && full16 && !out_q;
  wire wr_frm = do_wr && (aw_q == REG_FRAME) && full16;
  wire wr_rate = do_wr && (aw_q == REG_RATE) && ws_q[0];
  wire wr_ok = wr_cmd || wr_frm || wr_rate;
  wire rd_hs = s_axi_arvalid_in && !rvalid_q;
  wire rd_sts = rd_hs && (s_axi_araddr_in == REG_STATUS);

  // Comfort-noise and repeat frames get their unused words forced back to zero on the way out.
  wire first = idx_q == 8'h0;
  wire typed = size_q != 8'h0 && has_type_bits(rate_q);
  wire [1:0] mask_now = (first && typed) ? wd_q[1:0] : (first ? FT_63 : mask_q);
  logic [15:0] frm_d;
  always_comb begin
    frm_d = wd_q;
    if (mask_now == FT_CNF && idx_q >= SIG_CNF) begin
      frm_d = WORD_ZERO;
    end else if (mask_now == FT_REP) begin
      frm_d = first ? {14'h0, wd_q[1:0]} : WORD_ZERO;
    end
  end

  logic [31:0] rd_d;
  logic [1:0] rr_d;
  always_comb begin
    rd_d = 32'h0;
    rr_d = RESP_OKAY;
    unique case (s_axi_araddr_in)
      REG_CMD: rd_d = {16'h0, last_cmd_q};
      REG_STATUS: rd_d = {15'h0, port.sts_pending, port.sts_word};
      REG_FRAME: rd_d = 32'h0;
      REG_RATE: rd_d = {28'h0, rate_q};
      REG_HSTAT: rd_d = {idx_q, size_q, 14'h0, port.sts_pending, out_q};
      default: rr_d = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_q <= 5'h0;
      aw_full_q <= 1'b0;
      wd_q <= WORD_ZERO;
      ws_q <= 2'h0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && !aw_full_q) begin
        aw_q <= s_axi_awaddr_in;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid_in && !w_full_q) begin
        wd_q <= s_axi_wdata_in[15:0];
        ws_q <= s_axi_wstrb_in[1:0];
        w_full_q <= 1'b1;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
      if (rd_hs) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_d;
        rresp_q <= rr_d;
      end else if (s_axi_rready_in) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      out_q <= 1'b0;
      rate_q <= RATE_85;
      last_cmd_q <= WORD_ZERO;
      size_q <= 8'h0;
      idx_q <= 8'h0;
      mask_q <= FT_63;
      cmd_wr_q <= 1'b0;
      cmd_word_q <= WORD_ZERO;
      frm_wr_q <= 1'b0;
      frm_word_q <= WORD_ZERO;
    end else begin
      cmd_wr_q <= wr_cmd;
      frm_wr_q <= wr_frm;
      out_q <= wr_cmd || (out_q && !(rd_sts && port.sts_pending));
      if (wr_rate) begin
        rate_q <= wd_q[3:0];
      end
      if (wr_cmd) begin
        cmd_word_q <= wd_q;
        last_cmd_q <= wd_q;
        if (play_word_ok(wd_q)) begin
          size_q <= frame_words(wd_q[PB_FMT_LSB +: 3], rate_q);
          idx_q <= 8'h0;
        end
      end
      if (wr_frm) begin
        frm_word_q <= frm_d;
        mask_q <= mask_now;
        if (size_q != 8'h0) begin
          idx_q <= (idx_q == size_q - 8'h1) ? 8'h0 : idx_q + 8'h1;
        end
      end
    end
  end

  assign s_axi_awready_out = !aw_full_q;
  assign s_axi_wready_out = !w_full_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;
  assign port.cmd_wr = cmd_wr_q;
  assign port.cmd_word = cmd_word_q;
  assign port.sts_rd = rd_sts && port.sts_pending;
  assign port.frm_wr = frm_wr_q;
  assign port.frm_word = frm_word_q;
  assign port.speech_rate = rate_q;
endmodule
`default_nettype wire

// ==== dv/sfp_assertions.sv ====
// Concurrent checks on the host port between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module sfp_assertions (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Host port
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_word,
  input wire logic [15:0] sts_word,
  input wire logic sts_pending,
  input wire logic sts_rd
);
  import sfp_pkg::*;
  logic exp_q;
  logic [15:0] thr_q;
  wire logic is_play = cmd_word[15:7] == 9'h058 && cmd_word[3:2] == 2'h0
    && cmd_word[1:0] != PATH_RSV && cmd_word[6:4] inside {3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Mirrors the two-word threshold exchange so the checks know which word is data.
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exp_q <= 1'h0;
      thr_q <= THR_RESET;
    end else if (cmd_wr) begin
      exp_q <= !exp_q && cmd_word == CMD_THR_SET;
      if (exp_q) begin
        thr_q <= cmd_word;
      end
    end
  end

  sequence s_thr_cmd;
    cmd_wr && !exp_q && cmd_word == CMD_THR_SET;
  endsequence
  sequence s_thr_val;
    cmd_wr && exp_q;
  endsequence
  property p_thr_echo;
    s_thr_cmd |=> sts_word == CMD_THR_SET && sts_pending;
  endproperty
  a_thr_echo: assert property (p_thr_echo) else $error("threshold command not echoed");
  property p_thr_val;
    s_thr_val |=> sts_word == $past(cmd_word);
  endproperty
  a_thr_val: assert property (p_thr_val) else $error("threshold word not echoed");
  property p_thr_rd;
    cmd_wr && !exp_q && cmd_word == 16'hcf89 |=> sts_word == thr_q;
  endproperty
  a_thr_rd: assert property (p_thr_rd) else $error("threshold readback wrong");
  property p_pend_set;
    cmd_wr |=> sts_pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("response not flagged");
  property p_pend_clr;
    sts_rd && !cmd_wr |=> !sts_pending;
  endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending not cleared");
  property p_pend_hold;
    sts_pending && !sts_rd |=> sts_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped unread");
  property p_play_ok;
    cmd_wr && !exp_q && is_play |=> sts_word == $past(cmd_word);
  endproperty
  a_play_ok: assert property (p_play_ok) else $error("playback start not echoed");
  property p_play_bad;
    cmd_wr && !exp_q && cmd_word[15:12] == PB_TOP && !is_play |=> sts_word == WORD_ZERO;
  endproperty
  a_play_bad: assert property (p_play_bad) else $error("reserved start answered");
  property p_host_wait;
    sts_pending |-> !cmd_wr;
  endproperty
  a_host_wait: assert property (p_host_wait) else $error("command over unread status");
endmodule
`default_nettype wire

// ==== dv/speech_frame_level_and_playback_cmd_tb_top.sv ====
// Self-checking bench joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module speech_frame_level_and_playback_cmd_tb_top;
  import sfp_pkg::*;
  logic sys_clk_in, resetn_in, smp_valid, peak, active, done, pad;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, path;
  logic [15:0] smp, level;
  logic [2:0] fmt;
  logic [7:0] words;
  logic [3:0] wstrb;
  sfp_kind_type kind;
  int errors = 0;
  int n_tests = 0;
  int done_cnt = 0;
  sfp_if bus ();
  sfp_host sfp_host_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'h1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'h1), .port(bus.host));
  sfp_device sfp_device_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .port(bus.dev),
    .sample_valid_in(smp_valid), .sample_in(smp), .level_out(level), .peak_out(peak),
    .session_active_out(active), .playback_format_select_out(fmt),
    .transfer_path_select_out(path), .session_words_out(words), .frame_done_out(done),
    .frame_kind_out(kind), .pad_error_out(pad));
  sfp_assertions sfp_assertions_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .cmd_wr(bus.cmd_wr), .cmd_word(bus.cmd_word), .sts_word(bus.sts_word),
    .sts_pending(bus.sts_pending), .sts_rd(bus.sts_rd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Polls until the response is flagged; only the watchdog ends a wait that never does.
  task automatic get_sts(input logic [15:0] es);
    logic [31:0] d;
    do begin
      axi_rd(REG_HSTAT, d, RESP_OKAY);
    end while (!d[1]);
    axi_rd(REG_STATUS, d, RESP_OKAY);
    chk(d, {15'h0, 1'h1, es});
  endtask
  task automatic do_cmd(input logic [15:0] c, input logic [15:0] es);
    axi_wr(REG_CMD, {16'h0, c}, RESP_OKAY);
    get_sts(es);
  endtask
  task automatic t_defaults();
    logic [31:0] d;
    axi_wr(REG_CMD, 32'h0000_cf89, RESP_OKAY);
    axi_wr(REG_CMD, 32'h0000_cf88, RESP_SLVERR);
    get_sts(THR_RESET);
    axi_rd(REG_STATUS, d, RESP_OKAY);
    chk(d, {16'h0, THR_RESET});
    wstrb <= 4'h1;
    axi_wr(REG_CMD, 32'h0000_cf88, RESP_SLVERR);
    wstrb <= 4'hf;
    axi_rd(REG_HSTAT, d, RESP_OKAY);
    chk(d, 32'h0000_0000);
    axi_wr(5'h14, 32'h0, RESP_SLVERR);
    axi_wr(REG_STATUS, 32'h0, RESP_SLVERR);
    axi_rd(5'h14, d, RESP_SLVERR);
  endtask
  // Samples alternate +512 and -512, so a frame averages to 240 * 512 / 256.
  task automatic t_level(input logic [15:0] thr, input logic ep);
    do_cmd(CMD_THR_SET, CMD_THR_SET);
    do_cmd(thr, thr);
    for (int i = 0; i < 240; i++) begin
      @(posedge sys_clk_in);
      smp_valid <= 1'h1;
      smp <= i[0] ? 16'hfe00 : 16'h0200;
    end
    @(posedge sys_clk_in);
    smp_valid <= 1'h0;
    @(posedge sys_clk_in);
    chk({15'h0, peak, level}, {15'h0, ep, 16'h01e0});
    do_cmd(CMD_LVL_RD, 16'h01e0);
    do_cmd(16'hcf89, thr);
  endtask
  task automatic t_playback();
    logic [15:0] cw [9] = '{16'h2c13, 16'h2c02, 16'h2c20, 16'h2c41, 16'h2c53, 16'h2c63,
      16'h2c73, 16'h2c07, 16'h2c03};
    logic [7:0] ew [9] = '{8'h10, 8'h10, 8'h78, 8'h78, 8'h78, 8'hf0, 8'hf0, 8'hf0, 8'h0c};
    logic [8:0] acc = 9'h13c;
    logic [12:0] sel;
    logic [31:0] d;
    sel = 13'h0010;
    axi_wr(REG_RATE, 32'h1, RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      if (acc[i]) sel = {cw[i][6:4], cw[i][1:0], ew[i]};
      do_cmd(cw[i], acc[i] ? cw[i] : WORD_ZERO);
      chk({19'h0, fmt, path, words}, {19'h0, sel});
    end
    chk({31'h0, active}, 32'h1);
    axi_rd(REG_CMD, d, RESP_OKAY);
    chk(d, 32'h0000_2c03);
    axi_rd(REG_RATE, d, RESP_OKAY);
    chk(d, 32'h0000_0001);
  endtask
  // The session holds 12 words per frame; only word 0, word 1 and word k may be nonzero.
  task automatic send_frame(input logic [15:0] w0, w1, input int k, input logic [15:0] wk,
      input sfp_kind_type ek, input logic ep);
    int c;
    c = done_cnt;
    for (int i = 0; i < 12; i++) begin
      axi_wr(REG_FRAME, {16'h0, i == 0 ? w0 : i == 1 ? w1 : i == k ? wk : 16'h0}, RESP_OKAY);
    end
    for (int n = 0; n < 20 && done_cnt == c; n++) @(posedge sys_clk_in);
    chk(32'(done_cnt - c), 32'h1);
    chk({28'h0, kind, pad}, {28'h0, ek, ep});
  endtask
  task automatic t_frames();
    axi_wr(REG_RATE, 32'h3, RESP_OKAY);
    send_frame(ERASE_WORD, ERASE_WORD, 5, 16'h0, KIND_ERASE, 1'h0);
    send_frame(16'h0, 16'h0, 5, 16'h0, KIND_SILENCE, 1'h0);
    axi_wr(REG_RATE, 32'h1, RESP_OKAY);
    send_frame(16'h1230, 16'h5555, 11, 16'h0007, KIND_FULL63, 1'h0);
    send_frame(16'h1231, 16'h0, 11, 16'h0007, KIND_FULL53, 1'h1);
    send_frame(16'h1232, 16'h4444, 6, 16'h0009, KIND_CNF, 1'h0);
    send_frame(16'h00f3, 16'h0, 4, 16'h0009, KIND_REPEAT, 1'h0);
    axi_wr(REG_RATE, 32'h0, RESP_OKAY);
    send_frame(16'h1232, 16'h0, 5, 16'h0, KIND_PLAIN, 1'h0);
    chk({24'h0, words}, 32'h0000_000c);
  endtask
  task automatic tally_and_finish();
    $display("Tally: errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk_in = 1'h0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (done === 1'h1) done_cnt <= done_cnt + 1;
  end
  // The whole sequence needs well under 10000 cycles.
  initial begin
    #500000;
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    resetn_in = 1'h0;
    {awvalid, wvalid, arvalid, smp_valid} = 4'h0;
    {awaddr, araddr, wdata, smp} = 58'h0;
    wstrb = 4'hf;
    repeat (16) @(posedge sys_clk_in);
    resetn_in <= 1'h1;
    t_defaults();
    t_level(16'h0040, 1'h1);
    t_level(16'h01e0, 1'h0);
    t_playback();
    t_frames();
    tally_and_finish();
  end
endmodule
`default_nettype wire
